// *** bpc_pkg.sv ***
// Constants for the block-protection command controller: register map,
// field positions, flash command codes, unlock addresses and pin timing.
// Assumes a 10 MHz controller clock and a parallel NOR flash on the pins.
package bpc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets on the AHB-Lite bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_DATA   = 8'h08;
	localparam logic [7:0] REG_STAT   = 8'h0c;
	localparam logic [7:0] REG_RDATA  = 8'h10;
	localparam logic [7:0] REG_PWD_LO = 8'h14;
	localparam logic [7:0] REG_PWD_HI = 8'h18;

	localparam int CTRL_OP_LSB     = 0;
	localparam int CTRL_X16_BIT    = 8;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_REFUSE_BIT = 1;
	localparam int STAT_SET_LSB    = 4;

	localparam logic [63:0] PWD_RESET = 64'hffff_ffff_ffff_ffff;

	// ----------------------------------------------------------------
	// Software operations and active command sets
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_ENTER_LOCK = 4'h0;
	localparam logic [3:0] OP_ENTER_PWD  = 4'h1;
	localparam logic [3:0] OP_ENTER_NVP  = 4'h2;
	localparam logic [3:0] OP_ENTER_NVLB = 4'h3;
	localparam logic [3:0] OP_ENTER_VOL  = 4'h4;
	localparam logic [3:0] OP_ENTER_EMB  = 4'h5;
	localparam logic [3:0] OP_EXIT_PROT  = 4'h6;
	localparam logic [3:0] OP_EXIT_EMB   = 4'h7;
	localparam logic [3:0] OP_PROG       = 4'h8;
	localparam logic [3:0] OP_PROT_SET   = 4'h9;
	localparam logic [3:0] OP_PROT_CLR   = 4'ha;
	localparam logic [3:0] OP_CLR_NVP    = 4'hb;
	localparam logic [3:0] OP_UNLOCK     = 4'hc;
	localparam logic [3:0] OP_READ       = 4'hd;

	typedef enum logic [2:0] {
		SET_NONE = 3'h0,
		SET_LOCK = 3'h1,
		SET_PWD  = 3'h2,
		SET_NVP  = 3'h3,
		SET_NVLB = 3'h4,
		SET_VOL  = 3'h5,
		SET_EMB  = 3'h6
	} bpc_set_t;

	// ----------------------------------------------------------------
	// Flash command codes and unlock addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] CODE_UNLK1  = 8'haa;
	localparam logic [7:0] CODE_UNLK2  = 8'h55;
	localparam logic [7:0] CODE_LOCK   = 8'h40;
	localparam logic [7:0] CODE_PWD    = 8'h60;
	localparam logic [7:0] CODE_NVP    = 8'hc0;
	localparam logic [7:0] CODE_NVLB   = 8'h50;
	localparam logic [7:0] CODE_VOL    = 8'he0;
	localparam logic [7:0] CODE_EMB    = 8'h88;
	localparam logic [7:0] CODE_EXIT1  = 8'h90;
	localparam logic [7:0] CODE_EXIT2  = 8'h00;
	localparam logic [7:0] CODE_PROG   = 8'ha0;
	localparam logic [7:0] CODE_ERASE  = 8'h80;
	localparam logic [7:0] CODE_ERCONF = 8'h30;
	localparam logic [7:0] CODE_UNPW1  = 8'h25;
	localparam logic [7:0] CODE_UNPW2  = 8'h03;
	localparam logic [7:0] CODE_UNPW3  = 8'h29;
	localparam logic [7:0] BIT_PROT    = 8'h00;
	localparam logic [7:0] BIT_UNPROT  = 8'h01;

	localparam logic [23:0] A16_UNLK1 = 24'h000555;
	localparam logic [23:0] A16_UNLK2 = 24'h0002aa;
	localparam logic [23:0] A8_UNLK1  = 24'h000aaa;
	localparam logic [23:0] A8_UNLK2  = 24'h000555;
	localparam logic [23:0] A_ZERO    = 24'h000000;

	localparam int PWD_WORDS_X16 = 4;
	localparam int PWD_BYTES_X8  = 8;

	// ----------------------------------------------------------------
	// Pin timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_WP_NS       = 100;
	localparam int T_ACC_NS      = 100;
	localparam int T_HOLD_NS     = 100;
	localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// *** bpc_if.sv ***
// Carriers between the controller's own modules: one flash bus cycle
// request/answer, and the register write/read path from the bus slave.
// Assumes all ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none

interface bpc_cyc_if;
	logic        req;
	logic        wr;
	logic        x16;
	logic [23:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        done;
	modport mst (output req, output wr, output x16, output addr, output wdata, input rdata, input done);
	modport eng (input req, input wr, input x16, input addr, input wdata, output rdata, output done);
endinterface

interface bpc_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	modport bus (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport regs (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// *** bpc_ahb.sv ***
// AHB-Lite slave front end: zero wait states, OKAY always.
// Assumes single word transfers; the register file decodes the offset.
`timescale 1ns/1ns
`default_nettype none

module bpc_ahb (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_hsel,
	input  wire logic [7:0]  i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hwdata,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	bpc_reg_if.bus           rg
);
	logic       wr_pend_r;
	logic [7:0] wr_addr_r;
	wire        take = i_hsel & i_htrans[1] & i_hready;

	assign rg.wr_en   = wr_pend_r;
	assign rg.wr_addr = wr_addr_r;
	assign rg.wr_data = i_hwdata;
	assign rg.rd_addr = i_haddr;

	// --------------------------------------------------------
	// Address phase capture
	// --------------------------------------------------------
	// Read data is sampled in the address phase, so a read right
	// behind a write to the same register sees the old value.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_pend_r   <= 1'b0;
			wr_addr_r   <= 8'h00;
			o_hrdata    <= 32'h0000_0000;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else begin
			wr_pend_r <= take & i_hwrite;
			wr_addr_r <= i_haddr;
			if (take & ~i_hwrite) begin
				o_hrdata <= rg.rd_data;
			end
		end
	end
endmodule

`default_nettype wire

// *** bpc_cyc.sv ***
// Flash pin cycle engine: runs one asynchronous write or read cycle on
// CE#, OE#, WE#, address and the shared DQ15/A-1 data bus.
// Assumes the requester holds its fields stable until done.
`timescale 1ns/1ns
`default_nettype none

module bpc_cyc #(
	parameter int WP_CYC   = bpc_pkg::WP_CYC,
	parameter int ACC_CYC  = bpc_pkg::ACC_CYC,
	parameter int HOLD_CYC = bpc_pkg::HOLD_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	bpc_cyc_if.eng           cyc,
	input  wire logic [15:0] i_dq,
	output logic      [22:0] o_fa,
	output logic      [15:0] o_dq,
	output logic      [15:0] o_dq_oe,
	output logic             o_ce_n,
	output logic             o_oe_n,
	output logic             o_we_n
);
	typedef enum logic [3:0] {
		C_IDLE   = 4'b0001,
		C_SETUP  = 4'b0010,
		C_STROBE = 4'b0100,
		C_HOLD   = 4'b1000
	} bpc_cst_t;

	bpc_cst_t    st_r;
	logic [7:0]  cnt_r;
	logic [15:0] s1_r, s2_r, s3_r;
	logic [15:0] rdata_r;
	logic        done_r;

	// In byte mode DQ15 carries the lowest address bit in every cycle
	wire [22:0] fa_nxt  = cyc.x16 ? cyc.addr[22:0] : cyc.addr[23:1];
	wire [15:0] dq_nxt  = cyc.x16 ? cyc.wdata : {cyc.addr[0], 7'h00, cyc.wdata[7:0]};
	wire [15:0] oe_wr   = cyc.x16 ? 16'hffff : 16'h80ff;
	wire [15:0] oe_nxt  = cyc.wr ? oe_wr : (cyc.x16 ? 16'h0000 : 16'h8000);
	wire        settled = (s2_r == s3_r);
	wire [15:0] rd_cap  = cyc.x16 ? s3_r : {8'h00, s3_r[7:0]};

	assign cyc.rdata = rdata_r;
	assign cyc.done  = done_r;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_r <= 16'h0000;
			s2_r <= 16'h0000;
			s3_r <= 16'h0000;
		end else begin
			s1_r <= i_dq;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// --------------------------------------------------------
	// Cycle sequencer
	// --------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r    <= C_IDLE;
			cnt_r   <= 8'h00;
			rdata_r <= 16'h0000;
			done_r  <= 1'b0;
			o_fa    <= 23'h000000;
			o_dq    <= 16'h0000;
			o_dq_oe <= 16'h0000;
			o_ce_n  <= 1'b1;
			o_oe_n  <= 1'b1;
			o_we_n  <= 1'b1;
		end else begin
			done_r <= 1'b0;
			case (st_r)
				C_IDLE: if (cyc.req) begin
					o_fa    <= fa_nxt;
					o_dq    <= dq_nxt;
					o_dq_oe <= oe_nxt;
					o_ce_n  <= 1'b0;
					st_r    <= C_SETUP;
				end
				C_SETUP: begin
					o_we_n <= ~cyc.wr;
					o_oe_n <= cyc.wr;
					// Reads wait two more for the pin synchroniser
					cnt_r  <= cyc.wr ? 8'(WP_CYC) : 8'(ACC_CYC + 2);
					st_r   <= C_STROBE;
				end
				C_STROBE: if (cnt_r > 8'h01) begin
					cnt_r <= cnt_r - 8'h01;
				end else if (cyc.wr | settled) begin
					if (!cyc.wr) begin
						rdata_r <= rd_cap;
					end
					o_we_n <= 1'b1;
					o_oe_n <= 1'b1;
					cnt_r  <= 8'(HOLD_CYC);
					st_r   <= C_HOLD;
				end
				C_HOLD: if (cnt_r > 8'h01) begin
					cnt_r <= cnt_r - 8'h01;
				end else begin
					o_ce_n  <= 1'b1;
					o_dq_oe <= 16'h0000;
					done_r  <= 1'b1;
					st_r    <= C_IDLE;
				end
				default: st_r <= C_IDLE;
			endcase
		end
	end
endmodule

`default_nettype wire

// *** bpc_top.sv ***
// Block-protection command controller: software orders operations over
// AHB-Lite; the controller issues the flash write/read cycle sequences.
// Assumes one AHB-Lite master, word transfers only, and a flash whose
// DQ pins are resolved outside from o_FDQ / O_FDQ_OE.
//
// Behaviour
// - Three entry cycles: AA, 55, set code
// - Exit set with 90 then 00
// - Lock register: A0 plus data; read
// - A0 then one password byte per sequence
// - Unlock: 25, 03, password bytes, 29
// - C0 set: A0, 00 protects block
// - Lock-bit set: A0 then 00 programs
// - E0 set: A0 with 00 or 01
// - 88 enters extended block; exit AA,55,90,00
`timescale 1ns/1ns
`default_nettype none

module bpc_top #(
	parameter int WP_CYC   = bpc_pkg::WP_CYC,
	parameter int ACC_CYC  = bpc_pkg::ACC_CYC,
	parameter int HOLD_CYC = bpc_pkg::HOLD_CYC
) (
	input  wire logic        I_MCLK,
	input  wire logic        I_RST,
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic        I_HREADY,
	input  wire logic [31:0] I_HWDATA,
	output logic      [31:0] O_HRDATA,
	output logic             O_HREADYOUT,
	output logic             O_HRESP,
	output logic      [22:0] O_FA,
	output logic      [15:0] O_FDQ,
	output logic      [15:0] O_FDQ_OE,
	input  wire logic [15:0] I_FDQ,
	output logic             O_FCE_N,
	output logic             O_FOE_N,
	output logic             O_FWE_N
);
	// ----------------------------------------------------------------
	// Sequencer state and software registers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_REQ  = 3'b010,
		M_WAIT = 3'b100
	} bpc_mst_t;

	bpc_mst_t         st_r;
	bpc_pkg::bpc_set_t set_r;
	bpc_pkg::bpc_set_t set_nxt;
	logic [3:0]  op_r;
	logic        x16_r;
	logic [23:0] addr_r;
	logic [15:0] data_r;
	logic [63:0] pwd_r;
	logic [15:0] rdata_r;
	logic        refused_r;
	logic [3:0]  step_r;
	logic        req_r;

	bpc_reg_if rg ();
	bpc_cyc_if cyc ();

	wire unused_ok = &{1'b0, I_HSIZE, I_HADDR[31:8]};

	// ----------------------------------------------------------------
	// Bus slave and pin engine
	// ----------------------------------------------------------------
	bpc_ahb u_ahb (
		.i_clk       (I_MCLK),
		.i_rst       (I_RST),
		.i_hsel      (I_HSEL),
		.i_haddr     (I_HADDR[7:0]),
		.i_htrans    (I_HTRANS),
		.i_hwrite    (I_HWRITE),
		.i_hready    (I_HREADY),
		.i_hwdata    (I_HWDATA),
		.o_hrdata    (O_HRDATA),
		.o_hreadyout (O_HREADYOUT),
		.o_hresp     (O_HRESP),
		.rg          (rg.bus)
	);

	bpc_cyc #(
		.WP_CYC   (WP_CYC),
		.ACC_CYC  (ACC_CYC),
		.HOLD_CYC (HOLD_CYC)
	) u_cyc (
		.i_clk   (I_MCLK),
		.i_rst   (I_RST),
		.cyc     (cyc.eng),
		.i_dq    (I_FDQ),
		.o_fa    (O_FA),
		.o_dq    (O_FDQ),
		.o_dq_oe (O_FDQ_OE),
		.o_ce_n  (O_FCE_N),
		.o_oe_n  (O_FOE_N),
		.o_we_n  (O_FWE_N)
	);

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire        busy      = (st_r != M_IDLE);
	wire        wr_ctrl   = rg.wr_en & (rg.wr_addr == bpc_pkg::REG_CTRL);
	wire        wr_addr   = rg.wr_en & (rg.wr_addr == bpc_pkg::REG_ADDR) & ~busy;
	wire        wr_data   = rg.wr_en & (rg.wr_addr == bpc_pkg::REG_DATA) & ~busy;
	wire        wr_pwd_lo = rg.wr_en & (rg.wr_addr == bpc_pkg::REG_PWD_LO) & ~busy;
	wire        wr_pwd_hi = rg.wr_en & (rg.wr_addr == bpc_pkg::REG_PWD_HI) & ~busy;
	wire [3:0]  new_op    = rg.wr_data[bpc_pkg::CTRL_OP_LSB +: 4];
	wire        new_x16   = rg.wr_data[bpc_pkg::CTRL_X16_BIT];

	wire [31:0] rd_ctrl = (32'(op_r) << bpc_pkg::CTRL_OP_LSB) | (32'(x16_r) << bpc_pkg::CTRL_X16_BIT);
	wire [31:0] rd_stat = (32'(busy) << bpc_pkg::STAT_BUSY_BIT)
	                    | (32'(refused_r) << bpc_pkg::STAT_REFUSE_BIT)
	                    | (32'(set_r) << bpc_pkg::STAT_SET_LSB);
	assign rg.rd_data =
		(rg.rd_addr == bpc_pkg::REG_CTRL)   ? rd_ctrl :
		(rg.rd_addr == bpc_pkg::REG_ADDR)   ? {8'h00, addr_r} :
		(rg.rd_addr == bpc_pkg::REG_DATA)   ? {16'h0000, data_r} :
		(rg.rd_addr == bpc_pkg::REG_STAT)   ? rd_stat :
		(rg.rd_addr == bpc_pkg::REG_RDATA)  ? {16'h0000, rdata_r} :
		(rg.rd_addr == bpc_pkg::REG_PWD_LO) ? pwd_r[31:0] :
		(rg.rd_addr == bpc_pkg::REG_PWD_HI) ? pwd_r[63:32] : 32'h0000_0000;

	// ----------------------------------------------------------------
	// Legality of an order against the active set
	// ----------------------------------------------------------------
	// A set must be left before another is entered; sub-commands are
	// only sent where the device decodes them, so the device never
	// sees a stray write that would drop it back to its set idle.
	wire in_none = (set_r == bpc_pkg::SET_NONE);
	wire in_emb  = (set_r == bpc_pkg::SET_EMB);
	wire is_prot = (set_r == bpc_pkg::SET_NVP) | (set_r == bpc_pkg::SET_NVLB) | (set_r == bpc_pkg::SET_VOL);
	wire legal =
		(new_op <= bpc_pkg::OP_ENTER_EMB)  ? in_none :
		(new_op == bpc_pkg::OP_EXIT_PROT)  ? (~in_none & ~in_emb) :
		(new_op == bpc_pkg::OP_EXIT_EMB)   ? in_emb :
		(new_op == bpc_pkg::OP_PROG)       ? ((set_r == bpc_pkg::SET_LOCK) | (set_r == bpc_pkg::SET_PWD)) :
		(new_op == bpc_pkg::OP_PROT_SET)   ? is_prot :
		(new_op == bpc_pkg::OP_PROT_CLR)   ? (set_r == bpc_pkg::SET_VOL) :
		(new_op == bpc_pkg::OP_CLR_NVP)    ? (set_r == bpc_pkg::SET_NVP) :
		(new_op == bpc_pkg::OP_UNLOCK)     ? (set_r == bpc_pkg::SET_PWD) :
		(new_op == bpc_pkg::OP_READ)       ? ~in_none : 1'b0;
	wire start = wr_ctrl & ~busy & legal;

	// ----------------------------------------------------------------
	// Cycle table: what the current step of the order puts on the pins
	// ----------------------------------------------------------------
	wire [23:0] a_un1 = x16_r ? bpc_pkg::A16_UNLK1 : bpc_pkg::A8_UNLK1;
	wire [23:0] a_un2 = x16_r ? bpc_pkg::A16_UNLK2 : bpc_pkg::A8_UNLK2;
	wire [3:0]  pw_n  = x16_r ? 4'(bpc_pkg::PWD_WORDS_X16) : 4'(bpc_pkg::PWD_BYTES_X8);
	wire [3:0]  pw_k  = step_r - 4'h2;
	wire [15:0] pw_wd = pwd_r[{pw_k[1:0], 4'h0} +: 16];
	wire [15:0] pw_by = {8'h00, pwd_r[{pw_k[2:0], 3'h0} +: 8]};
	logic [7:0] entry_code;
	logic       t_wr;
	logic       t_last;
	logic [23:0] t_addr;
	logic [15:0] t_data;

	always_comb begin
		case (op_r)
			bpc_pkg::OP_ENTER_LOCK: entry_code = bpc_pkg::CODE_LOCK;
			bpc_pkg::OP_ENTER_PWD:  entry_code = bpc_pkg::CODE_PWD;
			bpc_pkg::OP_ENTER_NVP:  entry_code = bpc_pkg::CODE_NVP;
			bpc_pkg::OP_ENTER_NVLB: entry_code = bpc_pkg::CODE_NVLB;
			bpc_pkg::OP_ENTER_VOL:  entry_code = bpc_pkg::CODE_VOL;
			bpc_pkg::OP_ENTER_EMB:  entry_code = bpc_pkg::CODE_EMB;
			default:                entry_code = bpc_pkg::CODE_EXIT1;
		endcase
	end

	always_comb begin
		t_wr   = 1'b1;
		t_last = 1'b0;
		t_addr = bpc_pkg::A_ZERO;
		t_data = 16'h0000;
		case (op_r)
			bpc_pkg::OP_ENTER_LOCK, bpc_pkg::OP_ENTER_PWD, bpc_pkg::OP_ENTER_NVP,
			bpc_pkg::OP_ENTER_NVLB, bpc_pkg::OP_ENTER_VOL, bpc_pkg::OP_ENTER_EMB,
			bpc_pkg::OP_EXIT_EMB: begin
				case (step_r)
					4'h0: begin
						t_addr = a_un1;
						t_data = {8'h00, bpc_pkg::CODE_UNLK1};
					end
					4'h1: begin
						t_addr = a_un2;
						t_data = {8'h00, bpc_pkg::CODE_UNLK2};
					end
					4'h2: begin
						t_addr = a_un1;
						t_data = {8'h00, entry_code};
						t_last = (op_r != bpc_pkg::OP_EXIT_EMB);
					end
					default: begin
						t_data = {8'h00, bpc_pkg::CODE_EXIT2};
						t_last = 1'b1;
					end
				endcase
			end
			bpc_pkg::OP_EXIT_PROT: begin
				t_data = {8'h00, (step_r == 4'h0) ? bpc_pkg::CODE_EXIT1 : bpc_pkg::CODE_EXIT2};
				t_last = (step_r != 4'h0);
			end
			bpc_pkg::OP_PROG, bpc_pkg::OP_PROT_SET, bpc_pkg::OP_PROT_CLR: begin
				if (step_r == 4'h0) begin
					t_data = {8'h00, bpc_pkg::CODE_PROG};
				end else begin
					t_addr = addr_r;
					t_last = 1'b1;
					if (op_r == bpc_pkg::OP_PROG) begin
						t_data = data_r;
					end else begin
						t_data = {8'h00, (op_r == bpc_pkg::OP_PROT_SET) ? bpc_pkg::BIT_PROT : bpc_pkg::BIT_UNPROT};
					end
				end
			end
			bpc_pkg::OP_CLR_NVP: begin
				t_data = {8'h00, (step_r == 4'h0) ? bpc_pkg::CODE_ERASE : bpc_pkg::CODE_ERCONF};
				t_last = (step_r != 4'h0);
			end
			bpc_pkg::OP_UNLOCK: begin
				if (step_r == 4'h0) begin
					t_data = {8'h00, bpc_pkg::CODE_UNPW1};
				end else if (step_r == 4'h1) begin
					t_data = {8'h00, bpc_pkg::CODE_UNPW2};
				end else if (pw_k < pw_n) begin
					t_addr = {20'h00000, pw_k};
					t_data = x16_r ? pw_wd : pw_by;
				end else begin
					t_data = {8'h00, bpc_pkg::CODE_UNPW3};
					t_last = 1'b1;
				end
			end
			default: begin
				// Single read at the given address
				t_wr   = 1'b0;
				t_addr = addr_r;
				t_last = 1'b1;
			end
		endcase
	end

	always_comb begin
		case (op_r)
			bpc_pkg::OP_ENTER_LOCK: set_nxt = bpc_pkg::SET_LOCK;
			bpc_pkg::OP_ENTER_PWD:  set_nxt = bpc_pkg::SET_PWD;
			bpc_pkg::OP_ENTER_NVP:  set_nxt = bpc_pkg::SET_NVP;
			bpc_pkg::OP_ENTER_NVLB: set_nxt = bpc_pkg::SET_NVLB;
			bpc_pkg::OP_ENTER_VOL:  set_nxt = bpc_pkg::SET_VOL;
			bpc_pkg::OP_ENTER_EMB:  set_nxt = bpc_pkg::SET_EMB;
			bpc_pkg::OP_EXIT_PROT, bpc_pkg::OP_EXIT_EMB: set_nxt = bpc_pkg::SET_NONE;
			default:                set_nxt = set_r;
		endcase
	end

	assign cyc.req   = req_r;
	assign cyc.wr    = t_wr;
	assign cyc.x16   = x16_r;
	assign cyc.addr  = t_addr;
	assign cyc.wdata = t_data;

	// ----------------------------------------------------------------
	// Software register writes
	// ----------------------------------------------------------------
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			addr_r <= 24'h000000;
			data_r <= 16'h0000;
			pwd_r  <= bpc_pkg::PWD_RESET;
			x16_r  <= 1'b0;
			op_r   <= bpc_pkg::OP_READ;
			refused_r <= 1'b0;
		end else begin
			if (wr_addr) addr_r <= rg.wr_data[23:0];
			if (wr_data) data_r <= rg.wr_data[15:0];
			if (wr_pwd_lo) pwd_r[31:0] <= rg.wr_data;
			if (wr_pwd_hi) pwd_r[63:32] <= rg.wr_data;
			if (wr_ctrl & ~busy) begin
				refused_r <= ~legal;
				if (legal) begin
					op_r  <= new_op;
					x16_r <= new_x16;
				end
			end else if (wr_ctrl) begin
				refused_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Order sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			st_r    <= M_IDLE;
			set_r   <= bpc_pkg::SET_NONE;
			step_r  <= 4'h0;
			req_r   <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			req_r <= 1'b0;
			case (st_r)
				M_IDLE: if (start) begin
					step_r <= 4'h0;
					st_r   <= M_REQ;
				end
				M_REQ: begin
					req_r <= 1'b1;
					st_r  <= M_WAIT;
				end
				M_WAIT: if (cyc.done) begin
					if (!t_wr) begin
						rdata_r <= cyc.rdata;
					end
					if (t_last) begin
						set_r <= set_nxt;
						st_r  <= M_IDLE;
					end else begin
						step_r <= step_r + 4'h1;
						st_r   <= M_REQ;
					end
				end
				default: st_r <= M_IDLE;
			endcase
		end
	end
endmodule

`default_nettype wire

// *** bpc_flash_model.sv ***
// Behavioural flash decoding the protection command sets at its pins.
// Assumes x16 mode; a write is taken at the rise of the write strobe.
`timescale 1ns/1ns
`default_nettype none
module bpc_flash_model (
	input  wire logic [22:0] i_fa,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	output logic      [15:0] o_dq
);
	logic [2:0] set_r = 0;
	logic [1:0] n = 0;
	logic pa = 0, ex = 0, er = 0, lb = 1;
	logic [15:0] lr = '1, v, lst = 0, pw[4] = '{default: '1};
	logic [127:0] nv = '1, vl = '1;
	wire [6:0] b = i_fa[22:16];
	wire [7:0] d = i_dq[7:0];
	always_comb begin
		case (set_r)
			3'h1: v = lr;
			3'h2: v = pw[i_fa[1:0]];
			3'h3: v = {15'h0, nv[b]};
			3'h4: v = {15'h0, lb};
			3'h5: v = {15'h0, vl[b]};
			default: v = (set_r != 0 && b == 0) ? 16'hffff : i_fa[15:0] ^ 16'h5a5a;
		endcase
	end
	// Released bus shows the inverse, so a stale capture cannot pass
	assign o_dq = (!i_ce_n && !i_oe_n) ? v : ~lst;
	always @(posedge i_oe_n) lst <= v;
	always @(posedge i_we_n) if (!i_ce_n) begin
		if (set_r == 0 && n == 2) begin
			case (d)
				8'h40: set_r = 1;
				8'h60: set_r = 2;
				8'hc0: set_r = 3;
				8'h50: set_r = 4;
				8'he0: set_r = 5;
				8'h88: set_r = 6;
				default: set_r = 0;
			endcase
			n = 0;
		end else if (set_r == 0) begin
			n = (n == 0 && d == 8'haa && i_fa == 23'h555) ? 2'h1 : (n == 1 && d == 8'h55 && i_fa == 23'h2aa) ? 2'h2 : 2'h0;
		end else if (pa) begin
			case (set_r)
				3'h1: lr = i_dq;
				3'h2: pw[i_fa[1:0]] = i_dq;
				3'h3: nv[b] = d[0];
				3'h4: lb = 0;
				3'h5: vl[b] = d[0];
				default: ;
			endcase
			pa = 0;
		end else if (ex && d == 0) begin
			set_r = 0;
			ex = 0;
		end else begin
			pa = d == 8'ha0;
			ex = d == 8'h90;
			if (er && d == 8'h30 && lb) nv = '1;
			er = d == 8'h80;
			if (d == 8'h29 && set_r == 2) lb = 1;
		end
	end
endmodule
`default_nettype wire

// *** bpc_assertions.sv ***
// Checker on the controller's bus answer and flash strobes.
// Assumes default one-cycle pin timing and x16 cycles.
`timescale 1ns/1ns
`default_nettype none
module bpc_assertions (
	input wire logic        I_MCLK,
	input wire logic        I_RST,
	input wire logic        O_HREADYOUT,
	input wire logic        O_HRESP,
	input wire logic [22:0] O_FA,
	input wire logic [15:0] O_FDQ_OE,
	input wire logic        O_FCE_N,
	input wire logic        O_FOE_N,
	input wire logic        O_FWE_N
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	a_bus_okay: assert property (O_HREADYOUT && !O_HRESP) else $error("bus answer");
	a_we_in_ce: assert property (!O_FWE_N |-> !O_FCE_N) else $error("we outside ce");
	a_we_pulse: assert property ($fell(O_FWE_N) |=> O_FWE_N && !O_FCE_N) else $error("we pulse");
	a_strobe_excl: assert property (O_FWE_N || O_FOE_N) else $error("we and oe");
	a_addr_hold: assert property (!O_FCE_N && $past(!O_FCE_N) |-> $stable(O_FA)) else $error("addr moved");
	a_write_drive: assert property (!O_FWE_N |-> O_FDQ_OE == 16'hffff) else $error("write drive");
	a_read_float: assert property (!O_FOE_N |-> O_FDQ_OE == 16'h0) else $error("read drive");
	a_idle_quiet: assert property (O_FCE_N |-> O_FWE_N && O_FOE_N && O_FDQ_OE == 0) else $error("idle");
	a_ce_gap: assert property ($rose(O_FCE_N) |=> O_FCE_N) else $error("ce gap");
	cover property ($fell(O_FWE_N));
	cover property ($fell(O_FOE_N));
	cover property ($rose(O_FCE_N));
endmodule
bind bpc_top bpc_assertions bpc_assertions_inst (.*);
`default_nettype wire

// *** tb.sv ***
// Bench: orders go over AHB-Lite, results come back from a flash model.
// Assumes x16 mode and default pin timing.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic I_MCLK = 0, I_RST = 1, I_HWRITE = 0, rp = 0, O_HREADYOUT, O_HRESP, O_FCE_N, O_FOE_N, O_FWE_N;
	logic [1:0] I_HTRANS = 0;
	logic [31:0] I_HADDR = 0, I_HWDATA = 0, O_HRDATA, rv, eq[$], mq[$];
	logic [22:0] O_FA;
	logic [15:0] O_FDQ, O_FDQ_OE, I_FDQ, fq, p[4];
	int miscompares = 0, n_tests = 0, cyc = 0;
	assign I_FDQ = (O_FDQ_OE & O_FDQ) | (~O_FDQ_OE & fq);
	bpc_top bpc_top_inst (.I_HSEL(1'b1), .I_HSIZE(3'h2), .I_HREADY(O_HREADYOUT), .*);
	bpc_flash_model bpc_flash_model_inst (.i_fa(O_FA), .i_dq(I_FDQ), .i_ce_n(O_FCE_N), .i_oe_n(O_FOE_N),
		.i_we_n(O_FWE_N), .o_dq(fq));
	initial forever #50 I_MCLK = ~I_MCLK;
	task automatic chk(input string n, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c, input logic [31:0] e, m);
		I_HTRANS <= 2'h2;
		I_HWRITE <= w;
		I_HADDR <= {24'h0, a};
		do @(posedge I_MCLK); while (O_HREADYOUT !== 1'b1);
		I_HTRANS <= 2'h0;
		I_HWDATA <= d;
		if (c) begin
			eq.push_back(e);
			mq.push_back(m);
			rp <= 1'b1;
		end
		do @(posedge I_MCLK); while (O_HREADYOUT !== 1'b1);
		rv = O_HRDATA;
		rp <= 1'b0;
	endtask
	task automatic op(input logic [3:0] o, input logic [23:0] a, input logic [15:0] d, input logic [2:0] s);
		ahb(1, bpc_pkg::REG_ADDR, {8'h0, a}, 0, 0, 0);
		ahb(1, bpc_pkg::REG_DATA, {16'h0, d}, 0, 0, 0);
		ahb(1, bpc_pkg::REG_CTRL, {23'h0, 1'b1, 4'h0, o}, 0, 0, 0);
		rv = 1;
		for (int i = 0; i < 60 && rv[0]; i++) ahb(0, bpc_pkg::REG_STAT, 0, 0, 0, 0);
		ahb(0, bpc_pkg::REG_STAT, 0, 1, {25'h0, s, 4'h0}, 32'h71);
	endtask
	task automatic rdf(input logic [23:0] a, input logic [2:0] s, input logic [15:0] e);
		op(bpc_pkg::OP_READ, a, 0, s);
		ahb(0, bpc_pkg::REG_RDATA, 0, 1, {16'h0, e}, 32'hffff);
	endtask
	always @(posedge I_MCLK) begin
		cyc++;
		if (rp && eq.size() > 0) chk("hrdata", O_HRDATA & mq.pop_front(), eq.pop_front());
		if (cyc > 20000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(32'hff43));
		repeat (10) @(posedge I_MCLK);
		I_RST <= 1'b0;
		@(posedge I_MCLK);
		ahb(0, 8'h40, 0, 1, 0, 32'hffffffff);
		op(bpc_pkg::OP_ENTER_LOCK, 0, 0, 1);
		p[0] = 16'($urandom);
		op(bpc_pkg::OP_PROG, 0, p[0], 1);
		rdf(0, 1, p[0]);
		op(bpc_pkg::OP_EXIT_PROT, 0, 0, 0);
		op(bpc_pkg::OP_PROG, 0, 0, 0);
		ahb(0, bpc_pkg::REG_STAT, 0, 1, 2, 2);
		$display("lock test done");
		op(bpc_pkg::OP_ENTER_PWD, 0, 0, 2);
		for (int k = 3; k >= 0; k--) begin
			p[k] = 16'($urandom) | 16'h1;
			op(bpc_pkg::OP_PROG, 24'(k), p[k], 2);
		end
		for (int k = 0; k < 4; k++) rdf(24'(k), 2, p[k]);
		op(bpc_pkg::OP_EXIT_PROT, 0, 0, 0);
		$display("password test done");
		op(bpc_pkg::OP_ENTER_NVLB, 0, 0, 4);
		rdf(0, 4, 1);
		op(bpc_pkg::OP_PROT_SET, 0, 0, 4);
		rdf(0, 4, 0);
		op(bpc_pkg::OP_EXIT_PROT, 0, 0, 0);
		op(bpc_pkg::OP_ENTER_NVP, 0, 0, 3);
		op(bpc_pkg::OP_PROT_SET, 24'h030000, 0, 3);
		rdf(24'h030000, 3, 0);
		op(bpc_pkg::OP_CLR_NVP, 0, 0, 3);
		rdf(24'h030000, 3, 0);
		op(bpc_pkg::OP_EXIT_PROT, 0, 0, 0);
		op(bpc_pkg::OP_ENTER_PWD, 0, 0, 2);
		op(bpc_pkg::OP_UNLOCK, 0, 0, 2);
		op(bpc_pkg::OP_EXIT_PROT, 0, 0, 0);
		op(bpc_pkg::OP_ENTER_NVP, 0, 0, 3);
		op(bpc_pkg::OP_CLR_NVP, 0, 0, 3);
		rdf(24'h030000, 3, 1);
		op(bpc_pkg::OP_EXIT_PROT, 0, 0, 0);
		$display("nonvolatile test done");
		op(bpc_pkg::OP_ENTER_VOL, 0, 0, 5);
		op(bpc_pkg::OP_PROT_SET, 24'h050000, 0, 5);
		rdf(24'h050000, 5, 0);
		op(bpc_pkg::OP_PROT_CLR, 24'h050000, 0, 5);
		rdf(24'h050000, 5, 1);
		op(bpc_pkg::OP_EXIT_PROT, 0, 0, 0);
		op(bpc_pkg::OP_ENTER_EMB, 0, 0, 6);
		rdf(24'h010004, 6, 16'h5a5e);
		rdf(24'h000004, 6, 16'hffff);
		op(bpc_pkg::OP_EXIT_EMB, 0, 0, 0);
		$display("volatile and ext test done");
		end_of_test();
	end
endmodule
`default_nettype wire
